// >>> shared/dpm_defs.svh
// timing counts and field constants for the dual-port memory host controller
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH
`define DPM_CLK_NS 50
`define DPM_ADDR_W 12
`define DPM_DATA_W 8
`define DPM_SEM_SEL_W 3
`define DPM_MBOX_RIGHT 12'hFFF
`define DPM_MBOX_LEFT 12'hFFE
// minimum pulse widths, access, delay and settle times in ns, rounded up to whole cycles below
`define DPM_WR_PULSE_NS 20
`define DPM_RD_ACCESS_NS 25
`define DPM_PORT_DELAY_NS 30
`define DPM_FLAG_PULSE_NS 10
`define DPM_BUSY_SETTLE_NS 20
`define DPM_CYC(ns) (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_WR_CYC `DPM_CYC(`DPM_WR_PULSE_NS)
`define DPM_RD_CYC `DPM_CYC(`DPM_RD_ACCESS_NS + `DPM_PORT_DELAY_NS)
`define DPM_FLAG_CYC `DPM_CYC(`DPM_FLAG_PULSE_NS)
`define DPM_BUSY_CYC `DPM_CYC(`DPM_BUSY_SETTLE_NS)
`endif

// >>> shared/dpm_pkg.sv
// types for the dual-port memory host controller
package dpm_pkg;
    typedef enum logic [2:0] {
        DPM_IDLE = 3'b000,
        DPM_SETUP = 3'b001,
        DPM_STROBE = 3'b010,
        DPM_SAMPLE = 3'b011,
        DPM_GAP = 3'b100
    } dpm_state_t;
endpackage : dpm_pkg

// >>> core/dpm_cnt.sv
// small down-counter used for strobe widths and gaps
`timescale 1ns/10ps
`default_nettype none
module dpm_cnt #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // no load term: callers load on done, which would close a loop
    assign done = (cnt_q == '0);
endmodule : dpm_cnt
`default_nettype wire

// >>> core/dpm_host.sv
// host controller driving one port of the dual-port memory
`timescale 1ns/10ps
`default_nettype none
`include "dpm_defs.svh"
module dpm_host #(
    parameter int AW = `DPM_ADDR_W,
    parameter int DW = `DPM_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_token,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [DW-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [DW-1:0] rsp_rdata,
    output logic mailbox_pending,
    output logic busy_seen,
    // device pins
    output logic [AW-1:0] dev_addr,
    output logic array_select_n,
    output logic token_latch_select_n,
    output logic write_strobe_n,
    output logic output_drive_enable_n,
    output logic [DW-1:0] dev_data_out,
    output logic dev_data_oe,
    input wire logic [DW-1:0] dev_data_in,
    input wire logic busy_n,
    input wire logic mailbox_flag_n
);
    import dpm_pkg::*;
    localparam int CW = 4;
    dpm_state_t st_q, st_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic wr_q, wr_d, tok_q, tok_d;
    logic cs_n_q, cs_n_d, sem_n_q, sem_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic doe_q, doe_d, rv_q, rv_d, rdy_q, rdy_d, mb_q, bs_q;
    logic ld;
    logic [CW-1:0] ldv;
    logic cnt_done;
    dpm_cnt #(.W(CW)) u_cnt (
        .clk(clk),
        .reset(reset),
        .load(ld),
        .value(ldv),
        .done(cnt_done)
    );
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        wr_d = wr_q;
        tok_d = tok_q;
        cs_n_d = cs_n_q;
        sem_n_d = sem_n_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        doe_d = doe_q;
        rv_d = 1'b0;
        rdy_d = rdy_q;
        ld = 1'b0;
        ldv = '0;
        case (st_q)
            DPM_IDLE: begin
                if (cmd_valid && rdy_q) begin
                    rdy_d = 1'b0;
                    wr_d = cmd_write;
                    tok_d = cmd_token;
                    // only the low three bits matter for tokens
                    addr_d = cmd_token ? AW'(cmd_addr[`DPM_SEM_SEL_W-1:0])
                                       : cmd_addr;
                    // token writes carry only bit 0
                    wdata_d = cmd_token ? DW'(cmd_wdata[0])
                                        : cmd_wdata;
                    cs_n_d = cmd_token;
                    sem_n_d = !cmd_token;
                    st_d = DPM_SETUP;
                    // busy settle wait also covers slave contention
                    ld = 1'b1;
                    ldv = CW'(`DPM_BUSY_CYC);
                end
            end
            DPM_SETUP: begin
                // hold off array writes while busy is low; token writes and reads go ahead
                if (cnt_done && (busy_n || tok_q || !wr_q)) begin
                    st_d = DPM_STROBE;
                    ld = 1'b1;
                    if (wr_q) begin
                        we_n_d = 1'b0;
                        doe_d = 1'b1;
                        ldv = CW'(`DPM_WR_CYC);
                    end else begin
                        oe_n_d = 1'b0;
                        ldv = CW'(`DPM_RD_CYC);
                    end
                end
            end
            DPM_STROBE: begin
                if (cnt_done) begin
                    st_d = DPM_SAMPLE;
                    rdata_d = dev_data_in;
                end
            end
            DPM_SAMPLE: begin
                // strobes rise before select so the write ends cleanly
                we_n_d = 1'b1;
                oe_n_d = 1'b1;
                rv_d = !wr_q;
                st_d = DPM_GAP;
                ld = 1'b1;
                ldv = CW'(`DPM_FLAG_CYC);
            end
            DPM_GAP: begin
                cs_n_d = 1'b1;
                sem_n_d = 1'b1;
                doe_d = 1'b0;
                if (cnt_done) begin
                    st_d = DPM_IDLE;
                    rdy_d = 1'b1;
                end
            end
            default: begin
                st_d = DPM_IDLE;
                rdy_d = 1'b1;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= DPM_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            wr_q <= 1'b0;
            tok_q <= 1'b0;
            cs_n_q <= 1'b1;
            sem_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            doe_q <= 1'b0;
            rv_q <= 1'b0;
            rdy_q <= 1'b1;
            mb_q <= 1'b0;
            bs_q <= 1'b0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wr_q <= wr_d;
            tok_q <= tok_d;
            cs_n_q <= cs_n_d;
            sem_n_q <= sem_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            doe_q <= doe_d;
            rv_q <= rv_d;
            rdy_q <= rdy_d;
            mb_q <= !mailbox_flag_n;
            bs_q <= !busy_n;
        end
    end
    assign cmd_ready = rdy_q;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rdata_q;
    assign mailbox_pending = mb_q;
    assign busy_seen = bs_q;
    assign dev_addr = addr_q;
    assign array_select_n = cs_n_q;
    assign token_latch_select_n = sem_n_q;
    assign write_strobe_n = we_n_q;
    assign output_drive_enable_n = oe_n_q;
    assign dev_data_out = wdata_q;
    assign dev_data_oe = doe_q;
endmodule : dpm_host
`default_nettype wire

// >>> test/dpm_host_chk.sv
// port assertions for the host controller
`timescale 1ns/10ps
`default_nettype none
module dpm_host_chk #(
    parameter int AW = 12
) (
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [AW-1:0] dev_addr,
    input wire logic array_select_n,
    input wire logic token_latch_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_enable_n,
    input wire logic dev_data_oe,
    input wire logic busy_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence take_s(w);
        cmd_valid && cmd_ready && cmd_write == w;
    endsequence
    sequence oe_hold_s;
        !output_drive_enable_n [*4] ##1 output_drive_enable_n;
    endsequence
    sequence we_hold_s;
        !write_strobe_n [*3] ##1 write_strobe_n;
    endsequence
    a_select_excl: assert property (array_select_n || token_latch_select_n)
        else $error("both selects low");
    a_strobe_sel: assert property (!write_strobe_n |-> !(array_select_n && token_latch_select_n))
        else $error("strobe without select");
    a_drive_excl: assert property (dev_data_oe |-> output_drive_enable_n)
        else $error("bus driven from both sides");
    a_read_answer: assert property (take_s(1'b0) |-> ##7 rsp_valid)
        else $error("read answer late");
    a_write_end: assert property (take_s(1'b1) |-> ##[6:60] cmd_ready)
        else $error("write never ends");
    a_oe_width: assert property ($fell(output_drive_enable_n) |-> oe_hold_s)
        else $error("output enable width wrong");
    a_strobe_width: assert property ($fell(write_strobe_n) |-> we_hold_s)
        else $error("strobe width wrong");
    a_token_addr: assert property (!token_latch_select_n |-> dev_addr[AW-1:3] == '0)
        else $error("token address not masked");
    a_busy_block: assert property ($fell(write_strobe_n) && !array_select_n |-> $past(busy_n) || $past(busy_n, 2))
        else $error("write under busy");
endmodule : dpm_host_chk
bind dpm_host dpm_host_chk #(.AW(AW)) dpm_host_chk_inst (.clk, .reset,
    .cmd_valid, .cmd_write, .cmd_ready, .rsp_valid, .dev_addr,
    .array_select_n, .token_latch_select_n, .write_strobe_n,
    .output_drive_enable_n, .dev_data_oe, .busy_n);
`default_nettype wire

// >>> test/dpm_dev.sv
// behavioural model of one port of the dual-port memory
`timescale 1ns/10ps
`default_nettype none
module dpm_dev (
    // device pins
    input wire logic clk,
    input wire logic [11:0] dev_addr,
    input wire logic array_select_n,
    input wire logic token_latch_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_enable_n,
    input wire logic [7:0] dev_data_out,
    input wire logic mb_set,
    output logic [7:0] dev_data_in,
    output logic mailbox_flag_n
);
    logic [7:0] mem [0:4095];
    logic [7:0] tok;
    logic [7:0] last = 8'h00;
    logic flag = 1'b0;
    assign mailbox_flag_n = !flag;
    always @(posedge clk) begin
        if (!write_strobe_n && !array_select_n) mem[dev_addr] <= dev_data_out;
        if (!write_strobe_n && !token_latch_select_n) tok[dev_addr[2:0]] <= dev_data_out[0];
        if (mb_set) flag <= 1'b1;
        else if (!array_select_n && !output_drive_enable_n && dev_addr == 12'hFFE) flag <= 1'b0;
        last <= dev_data_in;
    end
    // released bus toggles so stale data never looks valid
    always_comb begin
        if (output_drive_enable_n || (array_select_n && token_latch_select_n)) dev_data_in = ~last;
        else if (!token_latch_select_n) dev_data_in = {8{tok[dev_addr[2:0]]}};
        else dev_data_in = mem[dev_addr];
    end
endmodule : dpm_dev
`default_nettype wire

// >>> test/test_dpm_host.sv
// self-checking bench for the host controller
`timescale 1ns/10ps
`default_nettype none
module test_dpm_host;
    import dpm_pkg::*;
    logic clk = 0, reset = 1, cmd_valid = 0, cmd_write = 0, cmd_token = 0;
    logic busy_n = 1, mb_set = 0, cmd_ready, rsp_valid, mailbox_pending;
    logic busy_seen, array_select_n, token_latch_select_n, write_strobe_n;
    logic output_drive_enable_n, dev_data_oe, mailbox_flag_n;
    logic [11:0] cmd_addr = '0, dev_addr, a;
    logic [7:0] cmd_wdata = '0, rsp_rdata, dev_data_in, dev_data_out;
    logic [7:0] em [int];
    logic [7:0] q [$];
    int miscompares = 0, tests_run = 0, cyc = 0;
    dpm_host dpm_host_inst (.clk, .reset, .cmd_valid, .cmd_write, .cmd_token,
        .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata,
        .mailbox_pending, .busy_seen, .dev_addr, .array_select_n,
        .token_latch_select_n, .write_strobe_n, .output_drive_enable_n,
        .dev_data_out, .dev_data_oe, .dev_data_in, .busy_n, .mailbox_flag_n);
    dpm_dev dpm_dev_inst (.clk, .dev_addr, .array_select_n,
        .token_latch_select_n, .write_strobe_n, .output_drive_enable_n,
        .dev_data_out, .mb_set, .dev_data_in, .mailbox_flag_n);
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic op(input logic w, t, input logic [11:0] ad, input logic [7:0] d);
        {cmd_valid, cmd_write, cmd_token, cmd_addr, cmd_wdata} = {1'b1, w, t, ad, d};
        do @(posedge clk); while (cmd_ready !== 1'b1);
        #5 cmd_valid = 0;
        do @(posedge clk) #5; while (cmd_ready !== 1'b1);
    endtask : op
    task automatic rd(input logic t, input logic [11:0] ad, input logic [7:0] e);
        q.push_back(e);
        op(1'b0, t, ad, 8'h00);
    endtask : rd
    // oldest expectation meets each answer
    always @(posedge clk) if (rsp_valid === 1'b1) chk(rsp_rdata, q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        void'($urandom(32'hC709));
        repeat (2) @(posedge clk);
        #5 reset = 0;
        for (int i = 0; i < 8; i++) op(1, 1, {9'h1FF, 3'(i)}, 8'hFF);
        for (int i = 0; i < 8; i++) rd(1, 12'(i), 8'hFF);
        op(1, 1, 12'hAB5, 8'hFE);
        rd(1, 12'h005, 8'h00);
        op(1, 1, 12'h005, 8'h01);
        rd(1, 12'hFF5, 8'hFF);
        for (int i = 0; i < 12; i++) begin
            a = (i < 2) ? 12'hFFE + 12'(i) : 12'($urandom);
            em[a] = 8'($urandom);
            op(1, 0, a, em[a]);
        end
        foreach (em[k]) rd(0, 12'(k), em[k]);
        mb_set = 1;
        @(posedge clk) #5 mb_set = 0;
        repeat (2) @(posedge clk);
        #5 chk({7'h0, mailbox_pending}, 8'h01);
        rd(0, 12'hFFE, em[12'hFFE]);
        chk({7'h0, mailbox_pending}, 8'h00);
        busy_n = 0;
        fork
            op(1, 0, 12'h123, 8'h5A);
            begin
                repeat (8) @(posedge clk);
                #5 chk({7'h0, busy_seen}, 8'h01);
                chk({7'h0, cmd_ready}, 8'h00);
                busy_n = 1;
            end
        join
        rd(0, 12'h123, 8'h5A);
        results();
    end
endmodule : test_dpm_host
`default_nettype wire
